//--- rtl/rxbm_pkg.sv
package rxbm_pkg;
  // Register byte offsets on the plain port
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RCR = 8'h04;
  localparam logic [7:0] OFS_TX_UPPER = 8'h08;
  localparam logic [7:0] OFS_RX_UPPER = 8'h0C;
  localparam logic [7:0] OFS_RING_UPPER = 8'h10;
  localparam logic [7:0] OFS_RING_START = 8'h14;
  localparam logic [7:0] OFS_RING_END = 8'h18;
  localparam logic [7:0] OFS_RING_RD = 8'h1C;
  localparam logic [7:0] OFS_RING_WR = 8'h20;
  localparam logic [7:0] OFS_CDA = 8'h24;
  localparam logic [7:0] OFS_CBA_LO = 8'h28;
  localparam logic [7:0] OFS_CBA_HI = 8'h2C;
  localparam logic [7:0] OFS_RWC_LO = 8'h30;
  localparam logic [7:0] OFS_RWC_HI = 8'h34;
  localparam logic [7:0] OFS_SEQ = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3C;
  // Command register bits
  localparam int CMD_RES_RD = 0;
  localparam int CMD_MODE32 = 1;
  // Status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_EOL_HELD = 1;
  localparam int ST_RING_EMPTY = 2;
  localparam int ST_LIST_EXH = 3;
  // Descriptor field indices
  localparam logic [2:0] FLD_STATUS = 3'h0;
  localparam logic [2:0] FLD_COUNT = 3'h1;
  localparam logic [2:0] FLD_PTR_LO = 3'h2;
  localparam logic [2:0] FLD_PTR_HI = 3'h3;
  localparam logic [2:0] FLD_SEQ = 3'h4;
  localparam logic [2:0] FLD_DESC_LAST = 3'h5;
  localparam logic [2:0] FLD_LINK = 3'h6;
  localparam logic [2:0] FLD_OWN = 3'h7;
  localparam logic [2:0] FLD_RES_LAST = 3'h3;
  // Resource descriptor span in fields
  localparam logic [2:0] RES_FIELDS = 3'h4;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] flags;
    logic [15:0] byte_count;
    logic [15:0] words;
    logic last;
  } rxbm_pkt_s;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rxbm_mreq_s;

  typedef enum {
    S_IDLE, S_RELINK, S_RELEASE, S_DESC, S_LINK, S_OWN, S_POST, S_RES, S_CMP
  } rxbm_state_e;
endpackage

//--- rtl/rxbm_top.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
// Function
// R1: After a stored packet write six descriptor words, read link, then write ownership.
// R2: In 32-bit mode only low half carries data; upper half may be written.
// R3: Status word is receive control config byte over received-packet flag byte.
// R4: Byte count field holds full frame length, address through frame check.
// R5: Packet pointer is the 32-bit buffer address at the packet's start.
// R6: Sequence field holds buffer-area number high byte, packet number low byte.
// R7: Packet number advances per packet; new buffer bumps area number, clears packet.
// R8: Explicit resource-read command never advances the buffer-area number.
// R9: Both sequence counters clear on reset and when software writes zero.
// R10: Link field bits 15..1 point to next descriptor; bit 0 marks end of list.
// R11: Host owns with non-zero; device zeroes ownership after advancing past it.
// R12: On last descriptor keep ownership; release it after the next packet.
// R13: Descriptor areas share one page; upper 16 bits from three upper registers.
// R14: Software loads ring start and end, end being last entry plus four fields.
// R15: Software loads ring read pointer and write pointer to vacant slot.
// R16: Software sets write pointer only to entry start, ring start or ring end.
// R17: Compare ring read and write pointers only after a whole entry is read.
// R18: Ring pointers join the ring upper register to form full addresses.
// R19: Ring entry is four contiguous fields: pointer low, high, count low, high.
// R20: 32-bit mode needs even count; buffer pointer aligned to field width.
// R21: Command bit fetches one entry into buffer and count registers, then clears.
// R22: Device fetches next ring entry automatically when its buffer is used up.
// R23: Software loads current descriptor address; joined with receive upper register.
// R24: After an entry read advance read pointer four fields, wrapping at ring end.
// R25: All pointer state sits in clocked registers with defined reset values.
module rxbm_top
  import rxbm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Packet completion from the receive engine
  input wire logic pkt_done,
  input wire rxbm_pkt_s pkt,
  output logic pkt_ready,
  // System memory master
  output logic mem_req,
  output rxbm_mreq_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  rxbm_state_e state;
  rxbm_pkt_s pk;
  logic [2:0] fidx;
  logic res_auto;
  logic cmd_res_rd;
  logic mode32;
  logic [7:0] rcr_cfg;
  logic [7:0] last_flags;
  logic [15:0] tx_list_upper_address;
  logic [15:0] rx_list_upper_address;
  logic [15:0] ring_upper_address;
  logic [15:0] ring_start;
  logic [15:0] ring_end_reg;
  logic [15:0] ring_read_pointer;
  logic [15:0] ring_write_pointer;
  logic [15:0] current_descriptor_address;
  logic [31:0] current_buffer_address;
  logic [31:0] remaining_word_count;
  logic [7:0] area_seq;
  logic [7:0] pkt_seq;
  logic [15:0] link_next;
  logic eol_held;
  logic ring_empty;
  logic list_exh;
  logic mem_done;
  logic needs_mem;
  rxbm_mreq_s next_cmd;
  logic [15:0] rd_mux;
  logic [15:0] next_ring_rd;

  // Field address inside a descriptor; fields are words or long words
  function automatic logic [15:0] fld(input logic [15:0] base, input logic [2:0] idx, input logic m32);
    fld = base + (m32 ? {11'h000, idx, 2'b00} : {12'h000, idx, 1'b0});
  endfunction

  assign mem_done = mem_req && mem_ack;

  always_comb begin
    next_ring_rd = fld(ring_read_pointer, RES_FIELDS, mode32); // [R24]
    if (next_ring_rd == ring_end_reg) begin
      next_ring_rd = ring_start; // [R24]
    end
  end

  // Memory request for the current state
  always_comb begin
    needs_mem = 1'b1;
    next_cmd.we = 1'b1;
    next_cmd.wdata = 32'h0000_0000; // [R2]
    next_cmd.addr = {rx_list_upper_address, fld(current_descriptor_address, fidx, mode32)}; // [R13] [R23]
    unique case (state)
      S_RELINK: begin
        next_cmd.we = 1'b0;
        next_cmd.addr = {rx_list_upper_address, fld(current_descriptor_address, FLD_LINK, mode32)}; // [R12]
      end
      S_RELEASE, S_OWN: begin
        next_cmd.addr = {rx_list_upper_address, fld(current_descriptor_address, FLD_OWN, mode32)}; // [R11]
      end
      S_DESC: begin
        unique case (fidx)
          FLD_STATUS: next_cmd.wdata[15:0] = {rcr_cfg, pk.flags}; // [R3]
          FLD_COUNT: next_cmd.wdata[15:0] = pk.byte_count; // [R4]
          FLD_PTR_LO: next_cmd.wdata[15:0] = current_buffer_address[15:0]; // [R5]
          FLD_PTR_HI: next_cmd.wdata[15:0] = current_buffer_address[31:16]; // [R5]
          FLD_SEQ: next_cmd.wdata[15:0] = {area_seq, pkt_seq}; // [R6]
          default: next_cmd.wdata[15:0] = RST_WORD;
        endcase
      end
      S_LINK: begin
        next_cmd.we = 1'b0;
        next_cmd.addr = {rx_list_upper_address, fld(current_descriptor_address, FLD_LINK, mode32)}; // [R1]
      end
      S_RES: begin
        next_cmd.we = 1'b0;
        next_cmd.addr = {ring_upper_address, fld(ring_read_pointer, fidx, mode32)}; // [R18] [R19]
      end
      S_IDLE, S_POST, S_CMP: needs_mem = 1'b0;
    endcase
  end

  // Memory master handshake: request held until acknowledged
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_req <= 1'b0;
      mem_cmd <= '0;
    end else if (ce) begin
      if (mem_req) begin
        if (mem_ack) begin
          mem_req <= 1'b0;
        end
      end else if (needs_mem) begin
        mem_req <= 1'b1;
        mem_cmd <= next_cmd;
      end
    end
  end

  // Software owned registers: config byte, mode, uppers, ring bounds and write pointer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rcr_cfg <= RST_BYTE;
      mode32 <= 1'b0;
      tx_list_upper_address <= RST_WORD;
      rx_list_upper_address <= RST_WORD;
      ring_upper_address <= RST_WORD;
      ring_start <= RST_WORD;
      ring_end_reg <= RST_WORD;
      ring_write_pointer <= RST_WORD;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        OFS_RCR: rcr_cfg <= reg_wdata[15:8];
        OFS_CMD: mode32 <= reg_wdata[CMD_MODE32];
        OFS_TX_UPPER: tx_list_upper_address <= reg_wdata; // [R13]
        OFS_RX_UPPER: rx_list_upper_address <= reg_wdata; // [R13]
        OFS_RING_UPPER: ring_upper_address <= reg_wdata; // [R13]
        OFS_RING_START: ring_start <= reg_wdata; // [R14]
        OFS_RING_END: ring_end_reg <= reg_wdata; // [R14]
        OFS_RING_WR: ring_write_pointer <= reg_wdata; // [R15] [R16]
        default: ;
      endcase
    end
  end

  // Descriptor and resource engine; hardware updates win over software writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      pk <= '0;
      fidx <= 3'h0;
      res_auto <= 1'b0;
      cmd_res_rd <= 1'b0;
      pkt_ready <= 1'b0;
      last_flags <= RST_BYTE;
      ring_read_pointer <= RST_WORD; // [R25]
      current_descriptor_address <= RST_WORD; // [R25]
      current_buffer_address <= 32'h0000_0000; // [R25]
      remaining_word_count <= 32'h0000_0000; // [R25]
      area_seq <= RST_BYTE; // [R9]
      pkt_seq <= RST_BYTE; // [R9]
      link_next <= RST_WORD;
      eol_held <= 1'b0;
      ring_empty <= 1'b0;
      list_exh <= 1'b0;
    end else if (ce) begin
      if (reg_wr) begin
        unique case (reg_addr)
          OFS_CMD: cmd_res_rd <= reg_wdata[CMD_RES_RD] | cmd_res_rd; // [R21]
          OFS_RING_RD: ring_read_pointer <= reg_wdata; // [R15]
          OFS_CDA: current_descriptor_address <= reg_wdata; // [R23]
          OFS_CBA_LO: current_buffer_address[15:0] <= reg_wdata;
          OFS_CBA_HI: current_buffer_address[31:16] <= reg_wdata;
          OFS_RWC_LO: remaining_word_count[15:0] <= reg_wdata;
          OFS_RWC_HI: remaining_word_count[31:16] <= reg_wdata;
          OFS_SEQ: begin
            area_seq <= reg_wdata[15:8]; // [R9]
            pkt_seq <= reg_wdata[7:0]; // [R9]
          end
          default: ;
        endcase
      end
      unique case (state)
        S_IDLE: begin
          fidx <= 3'h0;
          if (cmd_res_rd) begin
            pkt_ready <= 1'b0;
            res_auto <= 1'b0; // [R8]
            state <= S_RES; // [R21]
          end else if (pkt_done && pkt_ready) begin
            pkt_ready <= 1'b0;
            pk <= pkt;
            last_flags <= pkt.flags;
            state <= eol_held ? S_RELINK : S_DESC; // [R12]
          end else begin
            pkt_ready <= 1'b1;
          end
        end
        S_RELINK: if (mem_done) begin
          if (mem_rdata[0]) begin
            list_exh <= 1'b1; // Still end of list: packet dropped
            state <= S_IDLE;
          end else begin
            list_exh <= 1'b0;
            link_next <= {mem_rdata[15:1], 1'b0}; // [R10]
            state <= S_RELEASE;
          end
        end
        S_RELEASE: if (mem_done) begin
          current_descriptor_address <= link_next; // [R11] [R12]
          eol_held <= 1'b0;
          state <= S_DESC;
        end
        S_DESC: if (mem_done) begin
          if (fidx == FLD_DESC_LAST) begin
            state <= S_LINK; // [R1]
          end else begin
            fidx <= fidx + 3'h1;
          end
        end
        S_LINK: if (mem_done) begin
          if (mem_rdata[0]) begin
            eol_held <= 1'b1; // [R10] [R12]
            state <= S_POST;
          end else begin
            link_next <= {mem_rdata[15:1], 1'b0}; // [R10]
            state <= S_OWN;
          end
        end
        S_OWN: if (mem_done) begin
          current_descriptor_address <= link_next; // [R11]
          state <= S_POST;
        end
        S_POST: begin
          current_buffer_address <= current_buffer_address + {15'h0000, pk.words, 1'b0};
          remaining_word_count <= remaining_word_count - {16'h0000, pk.words};
          pkt_seq <= pkt_seq + 8'h01; // [R7]
          fidx <= 3'h0;
          res_auto <= 1'b1;
          state <= pk.last ? S_RES : S_IDLE; // [R22]
        end
        S_RES: if (mem_done) begin
          unique case (fidx)
            3'h0: current_buffer_address[15:0] <= mem_rdata[15:0]; // [R21]
            3'h1: current_buffer_address[31:16] <= mem_rdata[15:0]; // [R21]
            3'h2: remaining_word_count[15:0] <= mem_rdata[15:0]; // [R21]
            default: remaining_word_count[31:16] <= mem_rdata[15:0]; // [R21]
          endcase
          if (fidx == FLD_RES_LAST) begin
            ring_read_pointer <= next_ring_rd; // [R24]
            state <= S_CMP;
          end else begin
            fidx <= fidx + 3'h1;
          end
        end
        S_CMP: begin
          // Checked only once the whole entry is in, never mid-fetch
          ring_empty <= (ring_read_pointer == ring_write_pointer); // [R17]
          if (res_auto) begin
            area_seq <= area_seq + 8'h01; // [R7]
            pkt_seq <= RST_BYTE; // [R7]
          end else begin
            cmd_res_rd <= 1'b0; // [R21] [R8]
          end
          state <= S_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    unique case (reg_addr)
      OFS_CMD: rd_mux = {14'h0000, mode32, cmd_res_rd};
      OFS_RCR: rd_mux = {rcr_cfg, last_flags};
      OFS_TX_UPPER: rd_mux = tx_list_upper_address;
      OFS_RX_UPPER: rd_mux = rx_list_upper_address;
      OFS_RING_UPPER: rd_mux = ring_upper_address;
      OFS_RING_START: rd_mux = ring_start;
      OFS_RING_END: rd_mux = ring_end_reg;
      OFS_RING_RD: rd_mux = ring_read_pointer;
      OFS_RING_WR: rd_mux = ring_write_pointer;
      OFS_CDA: rd_mux = current_descriptor_address;
      OFS_CBA_LO: rd_mux = current_buffer_address[15:0];
      OFS_CBA_HI: rd_mux = current_buffer_address[31:16];
      OFS_RWC_LO: rd_mux = remaining_word_count[15:0];
      OFS_RWC_HI: rd_mux = remaining_word_count[31:16];
      OFS_SEQ: rd_mux = {area_seq, pkt_seq};
      OFS_STATUS: rd_mux = {12'h000, list_exh, ring_empty, eol_held, state != S_IDLE};
      default: rd_mux = RST_WORD;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= RST_WORD;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : RST_WORD;
    end
  end

endmodule // rxbm_top

//--- bench/rxbm_top_monitor.sv
`timescale 1ns/1ns
module rxbm_top_monitor
  import rxbm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // Register and packet ports
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic pkt_done,
  input wire logic pkt_ready,
  // Memory port
  input wire logic mem_req,
  input wire rxbm_mreq_s mem_cmd,
  input wire logic mem_ack
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request changed before its answer");
  a_req_drop: assert property (mem_req && mem_ack && ce |=> !mem_req)
    else $error("memory request stayed after its answer");
  a_upper_zero: assert property (mem_req && mem_cmd.we |-> mem_cmd.wdata[31:16] == 16'h0000)
    else $error("upper half of a write not zero");
  a_field_align: assert property (mem_req |-> !mem_cmd.addr[0])
    else $error("field address not word aligned");
  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data shown without a read");
  a_ready_drop: assert property (ce && pkt_done && pkt_ready |=> !pkt_ready)
    else $error("engine still ready after taking a packet");
  a_ready_rst: assert property ($rose(nrst) && ce |=> pkt_ready)
    else $error("engine not ready after reset");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |-> !mem_req && !pkt_ready && reg_rdata == 16'h0000)
    else $error("outputs active during reset");
  c_mem_write: cover property (mem_req && mem_ack && mem_cmd.we);
  c_mem_read: cover property (mem_req && mem_ack && !mem_cmd.we);
  c_pkt_taken: cover property (pkt_done && pkt_ready);
endmodule // rxbm_top_monitor

bind rxbm_top rxbm_top_monitor i_rxbm_top_monitor (.clock(clock), .nrst(nrst), .ce(ce), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pkt_done(pkt_done), .pkt_ready(pkt_ready), .mem_req(mem_req), .mem_cmd(mem_cmd),
  .mem_ack(mem_ack));

//--- bench/rxbm_mem_model.sv
`timescale 1ns/1ns
module rxbm_mem_model
  import rxbm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Wait states before each answer
  input wire logic [3:0] wait_cycles,
  // Memory port
  input wire logic mem_req,
  input wire rxbm_mreq_s mem_cmd,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [15:0] mem [logic [31:0]];
  logic [3:0] waited;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      waited <= 4'h0;
      mem_rdata <= 32'h00000000;
    end else if (mem_req && !mem_ack && waited >= wait_cycles) begin
      mem_ack <= 1'b1;
      waited <= 4'h0;
      // Only the low half is kept, full address is the key
      if (mem_cmd.we) mem[mem_cmd.addr] = mem_cmd.wdata[15:0];
      else mem_rdata <= {~mem_rdata[31:16], mem.exists(mem_cmd.addr) ? mem[mem_cmd.addr] : 16'hFFFF};
    end else begin
      mem_ack <= 1'b0;
      waited <= (mem_req && !mem_ack) ? waited + 4'h1 : 4'h0;
      // No stale data outside an answer
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // rxbm_mem_model

//--- bench/rxbm_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module rxbm_bench import rxbm_pkg::*;;
  logic clock, nrst, ce, reg_wr, reg_rd, pkt_done, pkt_ready, mem_req, mem_ack;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] mem_rdata;
  logic [3:0] wait_cycles;
  rxbm_pkt_s pkt;
  rxbm_mreq_s mem_cmd;
  int mismatches, cmp_count, cycles;
  rxbm_top i_rxbm_top (.clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_done(pkt_done), .pkt(pkt),
    .pkt_ready(pkt_ready), .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  rxbm_mem_model i_rxbm_mem_model (.clock(clock), .nrst(nrst), .wait_cycles(wait_cycles), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    logic [15:0] d;
    rd(a, d);
    `CHK(n, e, d & m)
  endtask
  task automatic chk_mem(input string n, input logic [31:0] a, input logic [15:0] e);
    `CHK(n, e, i_rxbm_mem_model.mem[a])
  endtask
  task automatic put(input logic [31:0] a, input logic [15:0] d);
    i_rxbm_mem_model.mem[a] = d;
  endtask
  task automatic send(input logic [7:0] f, input logic [15:0] c, input logic [15:0] w, input logic l);
    int n;
    @(posedge clock);
    pkt_done <= 1'b1;
    pkt <= '{f, c, w, l};
    @(posedge clock);
    pkt_done <= 1'b0;
    #1;
    for (n = 0; n < 400 && pkt_ready !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic t_reset();
    `CHK("ready", 1'b1, pkt_ready)
    chk_reg("seq", OFS_SEQ, 16'h0000);
    chk_reg("read ptr", OFS_RING_RD, 16'h0000);
    chk_reg("unmapped", 8'h40, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_fetch();
    logic [15:0] d;
    int n;
    wr(OFS_RING_UPPER, 16'h0012);
    wr(OFS_RING_START, 16'h0100);
    wr(OFS_RING_END, 16'h0110);
    wr(OFS_RING_RD, 16'h0108);
    wr(OFS_RING_WR, 16'h0100);
    for (n = 0; n < 4; n++) begin
      put(32'h00120108 + 2 * n, n == 0 ? 16'h4000 : n == 1 ? 16'h0005 : n == 2 ? 16'h0100 : 16'h0000);
      put(32'h00120100 + 2 * n, n == 0 ? 16'h6000 : n == 1 ? 16'h0007 : n == 2 ? 16'h0080 : 16'h0000);
    end
    wr(OFS_CMD, 16'h0001);
    d = 16'h0001;
    for (n = 0; n < 100 && d[CMD_RES_RD] !== 1'b0; n++) rd(OFS_CMD, d);
    `CHK("command bit", 1'b0, d[CMD_RES_RD])
    chk_reg("addr lo", OFS_CBA_LO, 16'h4000);
    chk_reg("addr hi", OFS_CBA_HI, 16'h0005);
    chk_reg("count lo", OFS_RWC_LO, 16'h0100);
    chk_reg("count hi", OFS_RWC_HI, 16'h0000);
    chk_reg("wrapped ptr", OFS_RING_RD, 16'h0100);
    chk_reg("ring empty", OFS_STATUS, 16'h0004, 16'h0004);
    chk_reg("seq after cmd", OFS_SEQ, 16'h0000);
    $display("resource fetch test done");
  endtask
  task automatic t_packet();
    wr(OFS_RCR, 16'hA500);
    wr(OFS_RX_UPPER, 16'h0034);
    wr(OFS_CDA, 16'h0200);
    put(32'h0034020C, 16'h0220);
    put(32'h0034020E, 16'h0001);
    put(32'h0034022C, 16'h0241);
    put(32'h0034022E, 16'h0002);
    send(8'h81, 16'h0040, 16'h0020, 1'b0);
    chk_mem("status", 32'h00340200, 16'hA581);
    chk_mem("byte count", 32'h00340202, 16'h0040);
    chk_mem("ptr lo", 32'h00340204, 16'h4000);
    chk_mem("ptr hi", 32'h00340206, 16'h0005);
    chk_mem("seq field", 32'h00340208, 16'h0000);
    chk_mem("ownership", 32'h0034020E, 16'h0000);
    chk_reg("desc addr", OFS_CDA, 16'h0220);
    chk_reg("seq next", OFS_SEQ, 16'h0001);
    $display("packet test done");
  endtask
  task automatic t_eol();
    @(posedge clock);
    wait_cycles <= 4'h3;
    send(8'h01, 16'h0020, 16'h0010, 1'b1);
    chk_mem("second ptr", 32'h00340224, 16'h4040);
    chk_mem("kept owner", 32'h0034022E, 16'h0002);
    chk_reg("eol held", OFS_STATUS, 16'h0002, 16'h0002);
    chk_reg("auto addr", OFS_CBA_LO, 16'h6000);
    chk_reg("auto ptr", OFS_RING_RD, 16'h0108);
    chk_reg("new area", OFS_SEQ, 16'h0100);
    put(32'h0034022C, 16'h0240);
    put(32'h0034024C, 16'h0261);
    put(32'h0034024E, 16'h0003);
    send(8'h01, 16'h0040, 16'h0010, 1'b0);
    chk_mem("released", 32'h0034022E, 16'h0000);
    chk_mem("appended", 32'h00340240, 16'hA501);
    chk_mem("appended seq", 32'h00340248, 16'h0100);
    wr(OFS_SEQ, 16'h0000);
    chk_reg("seq cleared", OFS_SEQ, 16'h0000);
    // Link still ends the list: packet dropped, ownership kept
    send(8'h02, 16'h0040, 16'h0010, 1'b0);
    chk_reg("list exhausted", OFS_STATUS, 16'h0008, 16'h0008);
    chk_mem("still owned", 32'h0034024E, 16'h0003);
    chk_reg("status flags", OFS_RCR, 16'hA502);
    $display("end of list test done");
  endtask
  task automatic t_wide();
    logic [15:0] d;
    int n;
    wr(OFS_RING_RD, 16'h0120);
    wr(OFS_RING_END, 16'h0130);
    for (n = 0; n < 4; n++) begin
      put(32'h00120120 + 4 * n, n == 0 ? 16'h8000 : n == 1 ? 16'h0009 : n == 2 ? 16'h0040 : 16'h0000);
    end
    wr(OFS_CMD, 16'h0003);
    d = 16'h0001;
    for (n = 0; n < 100 && d[CMD_RES_RD] !== 1'b0; n++) rd(OFS_CMD, d);
    `CHK("wide command bit", 1'b0, d[CMD_RES_RD])
    chk_reg("wide addr lo", OFS_CBA_LO, 16'h8000);
    chk_reg("wide addr hi", OFS_CBA_HI, 16'h0009);
    chk_reg("wide count lo", OFS_RWC_LO, 16'h0040);
    chk_reg("wide wrapped ptr", OFS_RING_RD, 16'h0100);
    $display("wide mode fetch test done");
  endtask
  task automatic t_rerst();
    wr(OFS_SEQ, 16'h0305);
    chk_reg("seq loaded", OFS_SEQ, 16'h0305);
    @(posedge clock);
    ce <= 1'b0;
    wr(OFS_CDA, 16'h1234);
    ce <= 1'b1;
    chk_reg("frozen", OFS_CDA, 16'h0240);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("ready again", 1'b1, pkt_ready)
    chk_reg("seq reset", OFS_SEQ, 16'h0000);
    chk_reg("desc addr reset", OFS_CDA, 16'h0000);
    $display("clock enable and reset test done");
  endtask
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    pkt_done = 1'b0;
    pkt = '0;
    wait_cycles = 4'h0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_fetch();
    t_packet();
    t_eol();
    t_wide();
    t_rerst();
    complete_run();
  end
endmodule // rxbm_bench
